// ---- inc/qrs_pkg.sv ----
package qrs_pkg;
  localparam logic [7:0] CMD_EXIT_QUAD   = 8'h0_0FF;
  localparam logic [7:0] CMD_ENTER_QUAD  = 8'h0_038;
  localparam logic [7:0] CMD_RST_ENABLE  = 8'h0_066;
  localparam logic [7:0] CMD_RST_DEVICE  = 8'h0_099;
  // write-type opcodes the host holds back during the power-up write delay
  localparam logic [7:0] CMD_WR_ENABLE   = 8'h0_006;
  localparam logic [7:0] CMD_WR_STATUS   = 8'h0_001;
  localparam logic [7:0] CMD_PAGE_PROG   = 8'h0_002;
  localparam logic [7:0] CMD_SECT_ERASE  = 8'h0_020;
  localparam logic [7:0] CMD_BLK_ERASE   = 8'h0_0D8;
  localparam logic [7:0] CMD_CHIP_ERASE  = 8'h0_0C7;

  localparam int CLK_PERIOD_NS     = 10;
  localparam int RESET_TIME_NS     = 30000;
  localparam int RESET_CYC         = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEL_DELAY_US      = 10;
  localparam int SEL_DELAY_CYC     = (SEL_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PUW_DELAY_MAX_MS  = 10;
  localparam int PUW_DELAY_CYC     = (PUW_DELAY_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYC      = 4;

  // power-on values of the volatile state
  localparam logic       WEL_RST   = 1'b0;
  localparam logic       SUS_RST   = 1'b0;
  localparam logic [7:0] RDP_RST   = 8'h0_000;
  localparam logic [7:0] CRM_RST   = 8'h0_000;
  localparam logic [2:0] WRAP_RST  = 3'h0;
  localparam logic [7:0] VSR_RST   = 8'h0_000;

  // host register map, word index
  localparam logic [1:0] REG_CMD    = 2'h0;
  localparam logic [1:0] REG_CFG    = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam int CMD_OP_LSB   = 0;
  localparam int CFG_QE_BIT   = 0;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_QUAD_BIT  = 1;
  localparam int ST_SEL_OK    = 2;
  localparam int ST_WR_OK     = 3;
  localparam int ST_RST_EN    = 4;
  localparam int ST_RST_RUN   = 5;

  function automatic logic is_write_type(input logic [7:0] op);
    is_write_type = (op == CMD_WR_ENABLE) || (op == CMD_WR_STATUS) ||
                    (op == CMD_PAGE_PROG) || (op == CMD_SECT_ERASE) ||
                    (op == CMD_BLK_ERASE) || (op == CMD_CHIP_ERASE);
  endfunction : is_write_type
endpackage : qrs_pkg

// ---- inc/qrs_link_if.sv ----
`timescale 1ns/10ps
interface qrs_link_if;
  logic       sel_n;
  logic       sck;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_out;
  logic [3:0] dev_io_oe;
  logic [3:0] io_level;

  // weak pull-up when nobody drives a line
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_level[i] = host_io_oe[i] ? host_io_out[i] : (dev_io_oe[i] ? dev_io_out[i] : 1'b1);
    end
  end

  modport host (output sel_n, output sck, output host_io_out, output host_io_oe,
                input io_level);
  modport device (input sel_n, input sck, output dev_io_out, output dev_io_oe,
                  input io_level);
endinterface : qrs_link_if

// ---- rtl/qrs_device.sv ----
`timescale 1ns/10ps
// What this block does
// - command FFh leaves quad command mode
// - mode switch keeps latch, suspend, wrap
// - accepted reset aborts internal work
// - reset clears all volatile settings
// - 66h and 99h accepted in both modes
// - reset only on 66h then 99h
// - other command after 66h cancels enable
// - commands ignored for reset time
// - host waits on its own busy only, not on suspend
// - host waits select delay after power-up
// - host delays write commands after power-up
// - power-up starts in serial mode
// - 38h ignored while quad enable clear
module qrs_device (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  qrs_link_if.device      link,
  input  wire logic       quad_enable_bit_i,
  input  wire logic       vol_load_i,
  input  wire logic       write_enable_latch_i,
  input  wire logic       erase_program_paused_flag_i,
  input  wire logic [7:0] read_parameter_bits_i,
  input  wire logic [7:0] continuous_read_mode_bits_i,
  input  wire logic [2:0] wrap_setting_bits_i,
  input  wire logic [7:0] vol_status_bits_i,
  output logic            quad_command_mode_o,
  output logic            write_enable_latch_o,
  output logic            erase_program_paused_flag_o,
  output logic [7:0]      read_parameter_bits_o,
  output logic [7:0]      continuous_read_mode_bits_o,
  output logic [2:0]      wrap_setting_bits_o,
  output logic [7:0]      vol_status_bits_o,
  output logic [7:0]      cmd_o,
  output logic            cmd_valid_o,
  output logic            abort_o,
  output logic            reset_busy_o,
  output logic            reset_enabled_o
);
  logic [1:0]  sel_sync_r;
  logic [1:0]  sck_sync_r;
  logic [7:0]  io_sync0_r;
  logic        sck_prev_r;
  logic [7:0]  shift_r;
  logic [3:0]  bit_cnt_r;
  logic        done_r;
  logic [15:0] rst_cnt_r;
  logic        sck_rise;
  logic        cmd_end;
  logic [7:0]  cmd_word;
  logic        rst_fire;
  logic        op_rst_enable;
  logic        op_rst_device;
  logic        op_exit_quad;
  logic        op_enter_quad;

  assign link.dev_io_out = 4'h0;
  assign link.dev_io_oe  = 4'h0;

  // select idles high, so its stages reset high as well
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sel_sync_r <= 2'h3;
    end else begin
      sel_sync_r <= {sel_sync_r[0], link.sel_n};
    end
  end

  // edge detector starts low like the idle clock, so reset gives no false edge
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sck_sync_r <= 2'h0;
      sck_prev_r <= 1'b0;
    end else begin
      sck_sync_r <= {sck_sync_r[0], link.sck};
      sck_prev_r <= sck_sync_r[1];
    end
  end

  // data takes the same two stages as the clock, so bit and edge stay aligned
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      io_sync0_r <= 8'h0_0FF;
    end else begin
      io_sync0_r <= {io_sync0_r[3:0], link.io_level};
    end
  end

  assign sck_rise = sck_sync_r[1] & ~sck_prev_r & ~sel_sync_r[1];
  assign cmd_word = quad_command_mode_o ? {shift_r[3:0], io_sync0_r[7:4]}
                                        : {shift_r[6:0], io_sync0_r[4]};
  assign cmd_end  = sck_rise & ~done_r &
                    (bit_cnt_r == (quad_command_mode_o ? 4'h1 : 4'h7));

  // lifting select drops a cut frame and every unit already shifted
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || sel_sync_r[1]) begin
      bit_cnt_r <= 4'h0;
    end else if (sck_rise && !done_r) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || sel_sync_r[1]) begin
      shift_r <= 8'h0_000;
    end else if (sck_rise && !done_r) begin
      shift_r <= cmd_word;
    end
  end

  // clocks after the last unit of a frame are ignored
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || sel_sync_r[1]) begin
      done_r <= 1'b0;
    end else if (cmd_end) begin
      done_r <= 1'b1;
    end
  end

  // no command counts while the reset is running
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cmd_valid_o <= 1'b0;
    end else begin
      cmd_valid_o <= cmd_end && !reset_busy_o;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cmd_o <= 8'h0_000;
    end else if (cmd_end && !reset_busy_o) begin
      cmd_o <= cmd_word;
    end
  end

  assign op_rst_enable = (cmd_o == qrs_pkg::CMD_RST_ENABLE);
  assign op_rst_device = (cmd_o == qrs_pkg::CMD_RST_DEVICE);
  assign op_exit_quad  = (cmd_o == qrs_pkg::CMD_EXIT_QUAD);
  assign op_enter_quad = (cmd_o == qrs_pkg::CMD_ENTER_QUAD);
  assign rst_fire      = cmd_valid_o && reset_enabled_o && op_rst_device;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reset_enabled_o <= 1'b0;
    end else if (cmd_valid_o) begin
      // any other command, 99h included, consumes the enable
      reset_enabled_o <= op_rst_enable;
    end
  end

  // abort is a one-cycle pulse for whatever internal work is running
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      abort_o <= 1'b0;
    end else begin
      abort_o <= rst_fire;
    end
  end

  // 16-bit counter covers the reset time at this clock; faster clocks need it wider
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rst_cnt_r    <= 16'h0_000;
      reset_busy_o <= 1'b0;
    end else if (rst_fire) begin
      reset_busy_o <= 1'b1;
      rst_cnt_r    <= 16'(qrs_pkg::RESET_CYC - 1);
    end else if (reset_busy_o) begin
      if (rst_cnt_r == 16'h0_000) begin
        reset_busy_o <= 1'b0;
      end else begin
        rst_cnt_r <= rst_cnt_r - 16'h0_001;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || rst_fire) begin
      quad_command_mode_o <= 1'b0;
    end else if (cmd_valid_o) begin
      if (quad_command_mode_o && op_exit_quad) begin
        quad_command_mode_o <= 1'b0;
      end else if (!quad_command_mode_o && op_enter_quad && quad_enable_bit_i) begin
        quad_command_mode_o <= 1'b1;
      end
    end
  end

  // mode changes never touch these; only a load or a reset does
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || rst_fire) begin
      write_enable_latch_o        <= qrs_pkg::WEL_RST;
      erase_program_paused_flag_o <= qrs_pkg::SUS_RST;
      read_parameter_bits_o       <= qrs_pkg::RDP_RST;
      continuous_read_mode_bits_o <= qrs_pkg::CRM_RST;
      wrap_setting_bits_o         <= qrs_pkg::WRAP_RST;
      vol_status_bits_o           <= qrs_pkg::VSR_RST;
    end else if (vol_load_i && !reset_busy_o) begin
      write_enable_latch_o        <= write_enable_latch_i;
      erase_program_paused_flag_o <= erase_program_paused_flag_i;
      read_parameter_bits_o       <= read_parameter_bits_i;
      continuous_read_mode_bits_o <= continuous_read_mode_bits_i;
      wrap_setting_bits_o         <= wrap_setting_bits_i;
      vol_status_bits_o           <= vol_status_bits_i;
    end
  end
endmodule : qrs_device

// ---- rtl/qrs_host.sv ----
`timescale 1ns/10ps
module qrs_host #(
  parameter int SEL_DELAY_CYC = qrs_pkg::SEL_DELAY_CYC,
  parameter int PUW_DELAY_CYC = qrs_pkg::PUW_DELAY_CYC,
  parameter int RESET_CYC     = qrs_pkg::RESET_CYC,
  parameter int SCK_HALF_CYC  = qrs_pkg::SCK_HALF_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  qrs_link_if.host         link,
  input  wire logic [1:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DESEL = 2'b10
  } qrs_hst_type;

  qrs_hst_type st_r;
  logic [7:0]  shift_r;
  logic [3:0]  bits_left_r;
  logic [7:0]  half_r;
  logic        sck_r;
  logic        quad_r;
  logic        qe_r;
  logic        rst_en_r;
  logic [7:0]  op_r;
  logic [31:0] wait_r;
  logic [31:0] puw_r;
  logic        sel_ok;
  logic        wr_ok;
  logic        rst_run;
  logic        busy;
  logic        cmd_wr;
  logic        can_go;
  logic [7:0]  new_op;
  logic        rd_done_r;

  assign new_op  = avs_writedata_i[qrs_pkg::CMD_OP_LSB +: 8];
  assign sel_ok  = (wait_r == 32'h0000_0000) && !rst_run;
  assign wr_ok   = (puw_r == 32'h0000_0000);
  assign busy    = (st_r != ST_IDLE) || !sel_ok;
  assign cmd_wr  = avs_write_i && (avs_address_i == qrs_pkg::REG_CMD);
  // write-type opcodes wait out the power-up write delay
  assign can_go  = !busy && (wr_ok || !qrs_pkg::is_write_type(new_op));
  // registered read data needs one cycle, so every read waits once
  assign avs_waitrequest_o = (cmd_wr && !can_go) || (avs_read_i && !rd_done_r);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rd_done_r <= 1'b0;
    end else begin
      rd_done_r <= avs_read_i && !rd_done_r;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      puw_r <= 32'(PUW_DELAY_CYC);
    end else if (puw_r != 32'h0000_0000) begin
      puw_r <= puw_r - 32'h0000_0001;
    end
  end

  // one counter covers the select delay and the device reset time
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wait_r  <= 32'(SEL_DELAY_CYC);
      rst_run <= 1'b0;
    end else if (st_r == ST_DESEL && half_r == 8'h0_000 && rst_en_r &&
                 op_r == qrs_pkg::CMD_RST_DEVICE) begin
      wait_r  <= 32'(RESET_CYC);
      rst_run <= 1'b1;
    end else if (wait_r != 32'h0000_0000) begin
      wait_r <= wait_r - 32'h0000_0001;
    end else begin
      rst_run <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      qe_r <= 1'b0;
    end else if (avs_write_i && avs_address_i == qrs_pkg::REG_CFG) begin
      qe_r <= avs_writedata_i[qrs_pkg::CFG_QE_BIT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !rd_done_r) begin
      avs_readdata_o <= 32'h0000_0000;
      case (avs_address_i)
        qrs_pkg::REG_CMD: avs_readdata_o[7:0] <= op_r;
        qrs_pkg::REG_CFG: avs_readdata_o[qrs_pkg::CFG_QE_BIT] <= qe_r;
        qrs_pkg::REG_STATUS: begin
          avs_readdata_o[qrs_pkg::ST_BUSY_BIT] <= busy;
          avs_readdata_o[qrs_pkg::ST_QUAD_BIT] <= quad_r;
          avs_readdata_o[qrs_pkg::ST_SEL_OK]   <= sel_ok;
          avs_readdata_o[qrs_pkg::ST_WR_OK]    <= wr_ok;
          avs_readdata_o[qrs_pkg::ST_RST_EN]   <= rst_en_r;
          avs_readdata_o[qrs_pkg::ST_RST_RUN]  <= rst_run;
        end
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // mode 0 framing: data moves on the falling edge, device samples on rising
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_r        <= ST_IDLE;
      shift_r     <= 8'h0_000;
      bits_left_r <= 4'h0;
      half_r      <= 8'h0_000;
      sck_r       <= 1'b0;
      op_r        <= 8'h0_000;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (cmd_wr && can_go) begin
            op_r        <= new_op;
            shift_r     <= new_op;
            bits_left_r <= quad_r ? 4'h2 : 4'h8;
            half_r      <= 8'(SCK_HALF_CYC - 1);
            st_r        <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (half_r != 8'h0_000) begin
            half_r <= half_r - 8'h0_001;
          end else begin
            half_r <= 8'(SCK_HALF_CYC - 1);
            sck_r  <= ~sck_r;
            if (sck_r) begin
              shift_r     <= quad_r ? {shift_r[3:0], 4'h0} : {shift_r[6:0], 1'b0};
              bits_left_r <= bits_left_r - 4'h1;
              if (bits_left_r == 4'h1) begin
                st_r <= ST_DESEL;
              end
            end
          end
        end
        ST_DESEL: begin
          if (half_r != 8'h0_000) begin
            half_r <= half_r - 8'h0_001;
          end else begin
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // tracks the mode the device is in after each finished command
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      quad_r   <= 1'b0;
      rst_en_r <= 1'b0;
    end else if (st_r == ST_DESEL && half_r == 8'h0_000) begin
      rst_en_r <= (op_r == qrs_pkg::CMD_RST_ENABLE);
      if (rst_en_r && op_r == qrs_pkg::CMD_RST_DEVICE) begin
        quad_r <= 1'b0;
      end else if (quad_r && op_r == qrs_pkg::CMD_EXIT_QUAD) begin
        quad_r <= 1'b0;
      end else if (!quad_r && op_r == qrs_pkg::CMD_ENTER_QUAD && qe_r) begin
        quad_r <= 1'b1;
      end
    end
  end

  assign link.sel_n       = (st_r == ST_IDLE);
  assign link.sck         = sck_r;
  assign link.host_io_out = quad_r ? shift_r[7:4] : {3'h0, shift_r[7]};
  assign link.host_io_oe  = (st_r == ST_IDLE) ? 4'h0 : (quad_r ? 4'hF : 4'h1);
endmodule : qrs_host

// ---- tb/qrs_monitor.sv ----
`timescale 1ns/10ps
module qrs_monitor (
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       sel_n,
  input wire logic       sck,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_oe,
  input wire logic       quad_enable_bit_i,
  input wire logic       vol_load_i,
  input wire logic       quad_command_mode_o,
  input wire logic       write_enable_latch_o,
  input wire logic       erase_program_paused_flag_o,
  input wire logic [7:0] read_parameter_bits_o,
  input wire logic [7:0] continuous_read_mode_bits_o,
  input wire logic [2:0] wrap_setting_bits_o,
  input wire logic [7:0] vol_status_bits_o,
  input wire logic [7:0] cmd_o,
  input wire logic       cmd_valid_o,
  input wire logic       abort_o,
  input wire logic       reset_busy_o,
  input wire logic       reset_enabled_o
);
  logic [11:0] busy_cnt_r;
  // counts busy cycles so the reset length is checked without a long repetition
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !reset_busy_o)
      busy_cnt_r <= 12'h000;
    else
      busy_cnt_r <= busy_cnt_r + 12'h001;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_sck_idle_low: assert property (sel_n |-> !sck)
    else $error("serial clock high while deselected");
  a_lines_released: assert property (sel_n |-> host_io_oe == 4'h0 && dev_io_oe == 4'h0)
    else $error("data line driven while deselected");
  a_abort_cause: assert property (abort_o |-> $past(cmd_valid_o) && $past(reset_enabled_o)
    && $past(cmd_o) == qrs_pkg::CMD_RST_DEVICE)
    else $error("abort without enable then reset pair");
  a_abort_clears: assert property (abort_o |=> reset_busy_o && !quad_command_mode_o
    && {write_enable_latch_o, erase_program_paused_flag_o, read_parameter_bits_o,
        continuous_read_mode_bits_o, wrap_setting_bits_o, vol_status_bits_o} == 29'h0)
    else $error("reset left volatile state or mode");
  a_busy_quiet: assert property (reset_busy_o && $past(reset_busy_o) |-> !cmd_valid_o)
    else $error("command accepted during reset");
  a_busy_length: assert property ($fell(reset_busy_o) |-> busy_cnt_r >= 12'hBB8
    && busy_cnt_r <= 12'hBBA)
    else $error("reset interval length wrong");
  a_quad_enter: assert property ($rose(quad_command_mode_o) |-> quad_enable_bit_i
    && cmd_o == qrs_pkg::CMD_ENTER_QUAD)
    else $error("quad mode entered without enable or opcode");
  a_quad_leave: assert property ($fell(quad_command_mode_o) |-> abort_o || reset_busy_o
    || cmd_o == qrs_pkg::CMD_EXIT_QUAD)
    else $error("quad mode left without exit or reset");
  a_mode_keeps: assert property ($changed(quad_command_mode_o) && !abort_o && !reset_busy_o
    && !$past(vol_load_i) |-> $stable(write_enable_latch_o)
    && $stable(erase_program_paused_flag_o) && $stable(wrap_setting_bits_o))
    else $error("mode switch changed latch, suspend or wrap");
  a_enable_rise: assert property ($rose(reset_enabled_o) |-> cmd_o == qrs_pkg::CMD_RST_ENABLE)
    else $error("reset enable without its opcode");
  a_enable_cancel: assert property (cmd_valid_o && cmd_o != qrs_pkg::CMD_RST_ENABLE
    |=> !reset_enabled_o)
    else $error("reset enable kept after other command");
endmodule : qrs_monitor

// ---- tb/test_qpi_exit_and_soft_reset.sv ----
`timescale 1ns/10ps
module test_qpi_exit_and_soft_reset;
  logic        sys_clk_i;
  logic        rst_n_i;
  logic [1:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        qe_i;
  logic        vol_load_i;
  logic [28:0] vol_i;
  logic        quad_o;
  logic        wel_o;
  logic        sus_o;
  logic [7:0]  rdp_o;
  logic [7:0]  crm_o;
  logic [2:0]  wrap_o;
  logic [7:0]  vsr_o;
  logic [7:0]  cmd_o;
  logic        cmd_valid_o;
  logic        abort_o;
  logic        busy_o;
  logic        rst_en_o;
  logic [31:0] s;
  logic [7:0]  snf_r;
  logic        snf_q;
  int          snf_n;
  int          num_errors;
  int          n_tests;
  int          n_abort;
  wire [28:0]  vol_o = {wel_o, sus_o, rdp_o, crm_o, wrap_o, vsr_o};
  localparam logic [28:0] VOL = 29'h1ABC_DEF5;
  qrs_link_if link ();
  qrs_device i_qrs_device (.sys_clk_i, .rst_n_i, .link(link), .quad_enable_bit_i(qe_i),
    .vol_load_i, .write_enable_latch_i(vol_i[28]), .erase_program_paused_flag_i(vol_i[27]),
    .read_parameter_bits_i(vol_i[26:19]), .continuous_read_mode_bits_i(vol_i[18:11]),
    .wrap_setting_bits_i(vol_i[10:8]), .vol_status_bits_i(vol_i[7:0]),
    .quad_command_mode_o(quad_o), .write_enable_latch_o(wel_o),
    .erase_program_paused_flag_o(sus_o), .read_parameter_bits_o(rdp_o),
    .continuous_read_mode_bits_o(crm_o), .wrap_setting_bits_o(wrap_o),
    .vol_status_bits_o(vsr_o), .cmd_o, .cmd_valid_o, .abort_o,
    .reset_busy_o(busy_o), .reset_enabled_o(rst_en_o));
  // short host reset stall lets frames reach the device while it is still busy
  qrs_host #(.SEL_DELAY_CYC(20), .PUW_DELAY_CYC(50), .RESET_CYC(40)) i_qrs_host (
    .sys_clk_i, .rst_n_i, .link(link), .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o);
  qrs_monitor i_qrs_monitor (.sys_clk_i, .rst_n_i, .sel_n(link.sel_n), .sck(link.sck),
    .host_io_oe(link.host_io_oe), .dev_io_oe(link.dev_io_oe), .quad_enable_bit_i(qe_i),
    .vol_load_i, .quad_command_mode_o(quad_o), .write_enable_latch_o(wel_o),
    .erase_program_paused_flag_o(sus_o), .read_parameter_bits_o(rdp_o),
    .continuous_read_mode_bits_o(crm_o), .wrap_setting_bits_o(wrap_o),
    .vol_status_bits_o(vsr_o), .cmd_o, .cmd_valid_o, .abort_o,
    .reset_busy_o(busy_o), .reset_enabled_o(rst_en_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(negedge link.sel_n) snf_n = 0;
  always @(posedge link.sck) begin
    if (!link.sel_n) begin
      snf_q = (link.host_io_oe === 4'hF);
      snf_r = snf_q ? {snf_r[3:0], link.io_level} : {snf_r[6:0], link.io_level[0]};
      snf_n++;
    end
  end
  always @(posedge sys_clk_i) if (abort_o === 1'b1) n_abort++;
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task wr(input logic [1:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wr
  task rd(input logic [1:0] a, output logic [31:0] d);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : rd
  task send(input logic [7:0] op, input logic q);
    wr(qrs_pkg::REG_CMD, {24'h00_0000, op});
    s = 32'h0000_0001;
    repeat (200) if (s[qrs_pkg::ST_BUSY_BIT] !== 1'b0) rd(qrs_pkg::REG_STATUS, s);
    repeat (10) @(posedge sys_clk_i);
    chk(snf_r, op, "wire byte");
    chk(snf_n, q ? 2 : 8, "wire units");
    chk(snf_q, q, "wire width");
    if (busy_o === 1'b0) chk(cmd_o, {24'h00_0000, op}, "device opcode");
  endtask : send
  task load(input logic [28:0] v);
    vol_i <= v;
    vol_load_i <= 1'b1;
    @(posedge sys_clk_i);
    vol_load_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
  endtask : load
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    #500000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
  initial begin
    {rst_n_i, avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
    {qe_i, vol_load_i, vol_i, num_errors, n_tests, n_abort, snf_n, snf_r} = '0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    chk(quad_o, 0, "power-up mode");
    rd(qrs_pkg::REG_STATUS, s);
    chk(s[qrs_pkg::ST_SEL_OK], 0, "select early");
    chk(s[qrs_pkg::ST_WR_OK], 0, "write early");
    repeat (60) @(posedge sys_clk_i);
    rd(qrs_pkg::REG_STATUS, s);
    chk(s[qrs_pkg::ST_SEL_OK], 1, "select later");
    chk(s[qrs_pkg::ST_WR_OK], 1, "write later");
    rd(2'h3, s);
    chk(s, 0, "unmapped read");
    $display("test power_up done");
    load(VOL);
    send(qrs_pkg::CMD_ENTER_QUAD, 0);
    chk(quad_o, 0, "enter without enable");
    qe_i <= 1'b1;
    wr(qrs_pkg::REG_CFG, 32'h0000_0001);
    send(qrs_pkg::CMD_ENTER_QUAD, 0);
    chk(quad_o, 1, "enter with enable");
    chk(vol_o, VOL, "state on enter");
    send(qrs_pkg::CMD_EXIT_QUAD, 1);
    chk(quad_o, 0, "exit quad");
    chk(vol_o, VOL, "state on exit");
    $display("test mode_switch done");
    send(qrs_pkg::CMD_RST_DEVICE, 0);
    send(qrs_pkg::CMD_RST_ENABLE, 0);
    send(qrs_pkg::CMD_WR_ENABLE, 0);
    send(qrs_pkg::CMD_RST_DEVICE, 0);
    chk(n_abort, 0, "reset without pair");
    chk(vol_o, VOL, "state kept");
    $display("test reset_guard done");
    for (int m = 0; m < 2; m++) begin
      load(VOL);
      rd(qrs_pkg::REG_STATUS, s);
      chk(s[qrs_pkg::ST_BUSY_BIT], 0, "busy before reset");
      chk(s[qrs_pkg::ST_QUAD_BIT], m[0], "host mode view");
      send(qrs_pkg::CMD_RST_ENABLE, m[0]);
      chk(rst_en_o, 1, "enable set");
      send(qrs_pkg::CMD_RST_DEVICE, m[0]);
      chk(n_abort, m + 1, "abort pulse");
      chk(vol_o, 0, "volatile cleared");
      chk(quad_o, 0, "serial after reset");
      send(qrs_pkg::CMD_RST_ENABLE, 0);
      chk(rst_en_o, 0, "ignored while busy");
      chk(busy_o, 1, "still resetting");
      repeat (4000) if (busy_o === 1'b1) @(posedge sys_clk_i);
      send(qrs_pkg::CMD_ENTER_QUAD, 0);
      chk(quad_o, 1, "accepted after reset");
      $display("test reset_mode_%0d done", m);
    end
    results();
  end
endmodule : test_qpi_exit_and_soft_reset
